// ---- logic/bck_cfg.svh ----
// Constants for the battery check control block
//
// What this block does
// - Enable bit powers reference and comparator
// - Flag reads 1 when input below reference
// - Flag meaningless while enable bit is 0
// - Four-bit control register at 37H
// - Reserved top bit reads 1, ignores writes
// - Reset clears enable and flag
// - Level select: 0 low, 1 full, resets 0
// - Comparator input is shared port bit three
// - Full supply forced half second after reset
`ifndef BCK_CFG_SVH
`define BCK_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define BCK_ADDR_W          8
`define BCK_DATA_W          4
`define BCK_CTRL_ADDR       8'h37
`define BCK_BIT_LEVEL       0
`define BCK_BIT_ENABLE      1
`define BCK_BIT_FLAG        2
`define BCK_BIT_RSVD        3
`define BCK_RSVD_VALUE      1'h1
`define BCK_UNMAPPED_DATA   4'h0

// ****************************************
// Timing
// ****************************************
`define BCK_CLK_PERIOD_NS   10
`define BCK_FORCE_TIME_MS   500
`define BCK_FORCE_CYCLES    ((`BCK_FORCE_TIME_MS * 1000000) / `BCK_CLK_PERIOD_NS)

`endif

// ---- logic/bck_pkg.sv ----
// Types for the battery check control block
package bck_pkg;

    typedef struct packed {
        logic       rsvd;
        logic       battery_low_flag;
        logic       comparator_enable;
        logic       regulator_level_select;
    } bck_ctrl_t;

    typedef struct packed {
        logic       comparator_power;
        logic       full_supply_level;
    } bck_analog_t;

    typedef enum logic [0:0] {
        BCK_FORCING,
        BCK_RUNNING
    } bck_state_t;

endpackage : bck_pkg

// ---- logic/bck_sync.sv ----
// Two-stage synchroniser for the comparator output
`timescale 1ns/1ps
`default_nettype none

module bck_sync (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    output var  logic sync_o
);

    logic stage1;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            stage1 <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end

endmodule : bck_sync

`default_nettype wire

// ---- logic/bck_top.sv ----
// Battery check control register, flag capture and supply level control
`timescale 1ns/1ps
`default_nettype none
`include "bck_cfg.svh"

module bck_top #(
    parameter int unsigned FORCE_CYCLES = `BCK_FORCE_CYCLES
) (
    input  wire logic                   mclk_i,
    input  wire logic                   rst_i,
    input  wire logic [`BCK_ADDR_W-1:0] addr_i,
    input  wire logic [`BCK_DATA_W-1:0] wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output var  logic [`BCK_DATA_W-1:0] rdata_o,
    input  wire logic                   comparator_out_i,
    input  wire logic                   shared_input_port_bit3_i,
    output var  logic                   port_bit3_o,
    output var  logic                   comparator_power_o,
    output var  logic                   logic_supply_output_o
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (FORCE_CYCLES < 1) begin : g_bad_force
        $error("FORCE_CYCLES must be at least one");
    end

    // ****************************************
    // Registers and decode
    // ****************************************
    bck_pkg::bck_ctrl_t   ctrl;
    bck_pkg::bck_state_t  state;
    bck_pkg::bck_analog_t analog;
    logic [31:0]          force_cnt;
    logic                 cmp_sync;
    logic                 next_force_done;

    wire logic hit      = (addr_i == `BCK_CTRL_ADDR);
    wire logic ctrl_wr  = wr_i && hit;
    wire logic ctrl_rd  = rd_i && hit;
    wire logic [`BCK_DATA_W-1:0] ctrl_view = {`BCK_RSVD_VALUE,
                                              ctrl.battery_low_flag,
                                              ctrl.comparator_enable,
                                              ctrl.regulator_level_select};
    wire logic [`BCK_DATA_W-1:0] next_rdata = ctrl_rd ? ctrl_view : `BCK_UNMAPPED_DATA;

    assign next_force_done = (force_cnt == FORCE_CYCLES - 1);

    // ****************************************
    // Comparator input synchroniser
    // ****************************************
    bck_sync u_sync (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .async_i (comparator_out_i),
        .sync_o  (cmp_sync)
    );

    // ****************************************
    // Control register
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ctrl.rsvd                   <= 1'b1;
            ctrl.battery_low_flag       <= 1'b0;
            ctrl.comparator_enable      <= 1'b0;
            ctrl.regulator_level_select <= 1'b0;
        end else begin
            ctrl.rsvd <= `BCK_RSVD_VALUE;
            if (ctrl_wr) begin
                ctrl.comparator_enable      <= wdata_i[`BCK_BIT_ENABLE];
                ctrl.regulator_level_select <= wdata_i[`BCK_BIT_LEVEL];
            end
            // Flag follows comparator only while enabled; writes never land
            if (ctrl.comparator_enable) begin
                ctrl.battery_low_flag <= cmp_sync;
            end
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rdata_o <= `BCK_UNMAPPED_DATA;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    // ****************************************
    // Supply level forcing after reset
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state     <= bck_pkg::BCK_FORCING;
            force_cnt <= 32'h0000_0000;
        end else begin
            unique case (state)
                bck_pkg::BCK_FORCING: begin
                    force_cnt <= force_cnt + 32'h0000_0001;
                    if (next_force_done) begin
                        state <= bck_pkg::BCK_RUNNING;
                    end
                end
                bck_pkg::BCK_RUNNING: begin
                    force_cnt <= force_cnt;
                end
            endcase
        end
    end

    assign analog.comparator_power  = ctrl.comparator_enable;
    assign analog.full_supply_level = (state == bck_pkg::BCK_FORCING)
                                      || ctrl.regulator_level_select;

    // ****************************************
    // Registered outputs
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            comparator_power_o    <= 1'b0;
            logic_supply_output_o <= 1'b1;
            port_bit3_o           <= 1'b0;
        end else begin
            comparator_power_o    <= analog.comparator_power;
            logic_supply_output_o <= analog.full_supply_level;
            port_bit3_o           <= shared_input_port_bit3_i;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    reserved_reads_one_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        ctrl_rd |=> rdata_o[`BCK_BIT_RSVD])
        else $error("Reserved bit did not read one");

    enable_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        ctrl_wr |=> ##1 (comparator_power_o == $past(wdata_i[`BCK_BIT_ENABLE], 2)))
        else $error("Comparator power did not follow enable write");

    flag_tracks_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        ctrl.comparator_enable |=> (ctrl.battery_low_flag == $past(cmp_sync)))
        else $error("Flag did not follow comparator");

    flag_holds_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (!ctrl.comparator_enable && ctrl_wr) |=> $stable(ctrl.battery_low_flag))
        else $error("Flag changed by write");

    reset_clears_a: assert property (@(posedge mclk_i)
        rst_i |=> (!ctrl.comparator_enable && !ctrl.battery_low_flag))
        else $error("Reset did not clear enable and flag");

    level_select_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state == bck_pkg::BCK_RUNNING && ctrl.regulator_level_select)
        |=> logic_supply_output_o)
        else $error("Full supply not selected");

    force_full_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state == bck_pkg::BCK_FORCING) |=> logic_supply_output_o)
        else $error("Supply not forced after reset");

    ctrl_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        ctrl_rd |=> (rdata_o[`BCK_BIT_ENABLE] == $past(ctrl.comparator_enable)))
        else $error("Read data does not match register");

    rdata_idle_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !ctrl_rd |=> (rdata_o == `BCK_UNMAPPED_DATA))
        else $error("Read data not zero outside a read");

    flag_frozen_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !ctrl.comparator_enable |=> $stable(ctrl.battery_low_flag))
        else $error("Flag moved while comparator disabled");

    port_follow_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        1'b1 |=> (port_bit3_o == $past(shared_input_port_bit3_i)))
        else $error("Port bit three did not follow pin");

    power_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !ctrl.comparator_enable |=> !comparator_power_o)
        else $error("Comparator powered while disabled");

    level_low_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state == bck_pkg::BCK_RUNNING && !ctrl.regulator_level_select)
        |=> !logic_supply_output_o)
        else $error("Low supply level not selected");

endmodule : bck_top

`default_nettype wire

// ---- verification/battery_check_control_tb.sv ----
// Self-checking testbench for the battery check control block
`timescale 1ns/1ps
`default_nettype none
`include "bck_cfg.svh"

module battery_check_control_tb;
    localparam int unsigned FC = 20;
    logic       mclk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [3:0] wdata_i = 4'h0;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic       comparator_out_i = 1'b0;
    logic       pin = 1'b0;
    logic [3:0] rdata_o;
    logic       port_bit3_o;
    logic       comparator_power_o;
    logic       logic_supply_output_o;
    int         err_total = 0;
    int         checked = 0;
    int         en = 0;
    int         lvl = 0;
    int         flag = 0;

    always #5 mclk_i = ~mclk_i;

    bck_top #(.FORCE_CYCLES(FC)) DUT (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .comparator_out_i(comparator_out_i), .shared_input_port_bit3_i(pin),
        .port_bit3_o(port_bit3_o), .comparator_power_o(comparator_power_o),
        .logic_supply_output_o(logic_supply_output_o));

    // ****************************************
    // Bus tasks and comparison
    // ****************************************
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [3:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [3:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk("rdata", exp, rdata_o);
        @(posedge mclk_i);
        #1;
        chk("rdata idle", 4'h0, rdata_o);
    endtask : rd

    task automatic summarize;
        if (err_total == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    function automatic logic [3:0] ctrl();
        return {1'b1, flag[0], en[0], lvl[0]};
    endfunction : ctrl

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(80));
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        chk("supply forced", 4'h1, {3'h0, logic_supply_output_o});
        chk("power", 4'h0, {3'h0, comparator_power_o});
        rd(`BCK_CTRL_ADDR, 4'h8);
        repeat (FC + 2) @(posedge mclk_i);
        #1;
        chk("supply low", 4'h0, {3'h0, logic_supply_output_o});
        for (int i = 0; i < 12; i++) begin
            wr(`BCK_CTRL_ADDR, {2'($urandom()), 2'(i)});
            en = i & 2;
            en = en >> 1;
            lvl = i & 1;
            comparator_out_i <= 1'($urandom());
            pin <= 1'($urandom());
            repeat (5) @(posedge mclk_i);
            #1;
            if (en == 1) flag = comparator_out_i;
            chk("power", 4'(en), {3'h0, comparator_power_o});
            chk("supply", 4'(lvl), {3'h0, logic_supply_output_o});
            chk("port", {3'h0, pin}, {3'h0, port_bit3_o});
            rd(`BCK_CTRL_ADDR, ctrl());
        end
        wr(8'h38, 4'hF);
        rd(8'h38, `BCK_UNMAPPED_DATA);
        rd(`BCK_CTRL_ADDR, ctrl());
        @(posedge mclk_i);
        rst_i <= 1'b1;
        @(posedge mclk_i);
        rst_i <= 1'b0;
        en = 0;
        lvl = 0;
        flag = 0;
        rd(`BCK_CTRL_ADDR, ctrl());
        chk("supply forced", 4'h1, {3'h0, logic_supply_output_o});
        chk("power", 4'h0, {3'h0, comparator_power_o});
        summarize();
    end
endmodule : battery_check_control_tb
`default_nettype wire
